//--- hdl/timer8_consts.svh
// Purpose: offsets, field positions, reset values and prescale counts
// Assumes: included wherever the timer core or its bench needs numbers
// Notes: offsets are byte addresses on a 32-bit apb bus
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// register byte offsets
`define OFS_TIMER_CONTROL_A 8'h00
`define OFS_TIMER_CONTROL_B 8'h04
`define OFS_COUNTER_VALUE 8'h08
`define OFS_COMPARE_VALUE_A 8'h0C
`define OFS_COMPARE_VALUE_B 8'h10
`define OFS_TIMER_FLAG 8'h14
`define OFS_TIMER_MASK 8'h18
`define OFS_TIMER_FLAG_CLEAR 8'h1C

// field positions
`define POS_WGM_LOW 0
`define POS_CS 0
`define POS_WGM_BIT2 3
`define POS_FLAG_OVF 0
`define POS_FLAG_CMP_A 1
`define POS_FLAG_CMP_B 2

// reset values
`define RST_BYTE 8'h00
`define RST_FLAGS 3'h0
`define RST_MODE 3'h0

// counter extremes
`define CNT_BOTTOM 8'h00
`define CNT_MAX 8'hFF

// prescaler tap masks (divide minus one)
`define PRE_DIV8_M 10'h007
`define PRE_DIV64_M 10'h03F
`define PRE_DIV256_M 10'h0FF
`define PRE_DIV1024_M 10'h3FF

`endif

//--- hdl/timer8_pkg.sv
// Purpose: types shared by the timer core and its bench
// Assumes: nothing beyond plain apb signalling
// Notes: numbers live in timer8_consts.svh
package timer8_pkg;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // event flags, one bit per interrupt source
    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } flags_t;

    // clock source select codes
    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } clock_source_t;

    // waveform mode codes
    typedef enum logic [2:0] {
        WGM_NORMAL = 3'b000,
        WGM_PC_MAX = 3'b001,
        WGM_CLEAR_ON_MATCH = 3'b010,
        WGM_FAST_MAX = 3'b011,
        WGM_RSV4 = 3'b100,
        WGM_PC_CMPA = 3'b101,
        WGM_RSV6 = 3'b110,
        WGM_FAST_CMPA = 3'b111
    } waveform_mode_t;

endpackage

//--- hdl/timer8_core.sv
// Purpose: 8-bit timer/counter core with two compare units and apb registers
// Assumes: single clock, synchronous active-low reset, zero-wait apb master
// Notes: external count pin is synchronised before any edge detection
`timescale 1ns/1ps
`include "timer8_consts.svh"
`default_nettype none

module timer8_core (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire timer8_pkg::apb_req_t apb_req_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // external count source
    input wire logic external_count_pin_i,
    // interrupt service and request
    input wire timer8_pkg::flags_t irq_ack_i,
    output logic irq_o,
    // observed counter state
    output logic [7:0] counter_value_o,
    output logic bottom_o,
    output logic max_o
);
    import timer8_pkg::*;

    // software registers
    logic [1:0] waveform_mode_low_r;
    logic waveform_mode_bit2_r;
    clock_source_t clock_source_select_r;
    logic [7:0] counter_value_r;
    logic [7:0] compare_value_a_r;
    logic [7:0] compare_value_b_r;
    flags_t timer_flag_r;
    flags_t timer_mask_r;
    logic [31:0] prdata_r;

    // timing state
    logic [9:0] prescale_r;
    logic ext_meta_r;
    logic ext_sync_r;
    logic ext_prev_r;
    logic count_down_r;
    logic match_block_r;

    // combinational terms
    waveform_mode_t waveform_mode_field;
    logic timer_tick;
    logic access_phase;
    logic setup_phase;
    logic wr_en;
    logic addr_ok;
    logic wr_counter;
    logic [7:0] top_value;
    logic at_bottom;
    logic at_max;
    logic at_top;
    logic match_a;
    logic match_b;
    logic [7:0] counter_nxt;
    logic count_down_nxt;
    logic overflow_evt;
    flags_t flag_set;
    flags_t flag_clr;

    // apb phase decode
    assign setup_phase = apb_req_i.psel && !apb_req_i.penable;
    assign access_phase = apb_req_i.psel && apb_req_i.penable;
    assign wr_en = access_phase && apb_req_i.pwrite && addr_ok;
    assign wr_counter = wr_en && (apb_req_i.paddr == `OFS_COUNTER_VALUE);

    // address decode, unmapped offsets answer with an error
    always_comb begin
        unique case (apb_req_i.paddr)
            `OFS_TIMER_CONTROL_A,
            `OFS_TIMER_CONTROL_B,
            `OFS_COUNTER_VALUE,
            `OFS_COMPARE_VALUE_A,
            `OFS_COMPARE_VALUE_B,
            `OFS_TIMER_FLAG,
            `OFS_TIMER_MASK,
            `OFS_TIMER_FLAG_CLEAR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // zero wait state answer
    assign pready_o = 1'b1;
    assign pslverr_o = access_phase && !addr_ok;
    assign prdata_o = prdata_r;

    // mode field assembled from both control registers
    assign waveform_mode_field = waveform_mode_t'({waveform_mode_bit2_r,
                                                   waveform_mode_low_r});

    // read data captured in the setup cycle
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_phase && !apb_req_i.pwrite) begin
            prdata_r <= 32'h0000_0000;
            unique case (apb_req_i.paddr)
                `OFS_TIMER_CONTROL_A: prdata_r[1:0] <= waveform_mode_low_r;
                `OFS_TIMER_CONTROL_B: prdata_r[3:0] <= {waveform_mode_bit2_r,
                                                        clock_source_select_r};
                `OFS_COUNTER_VALUE: prdata_r[7:0] <= counter_value_r;
                `OFS_COMPARE_VALUE_A: prdata_r[7:0] <= compare_value_a_r;
                `OFS_COMPARE_VALUE_B: prdata_r[7:0] <= compare_value_b_r;
                `OFS_TIMER_FLAG: prdata_r[2:0] <= timer_flag_r;
                `OFS_TIMER_MASK: prdata_r[2:0] <= timer_mask_r;
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // control register a: low mode bits
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            waveform_mode_low_r <= 2'(`RST_MODE);
        end else if (wr_en && apb_req_i.paddr == `OFS_TIMER_CONTROL_A) begin
            waveform_mode_low_r <= apb_req_i.pwdata[`POS_WGM_LOW +: 2];
        end
    end

    // control register b: clock source and top mode bit
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            waveform_mode_bit2_r <= 1'b0;
            clock_source_select_r <= CS_STOP;
        end else if (wr_en && apb_req_i.paddr == `OFS_TIMER_CONTROL_B) begin
            clock_source_select_r <= clock_source_t'(apb_req_i.pwdata[`POS_CS +: 3]);
            waveform_mode_bit2_r <= apb_req_i.pwdata[`POS_WGM_BIT2];
        end
    end

    // compare value a, also the top in some modes
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            compare_value_a_r <= `RST_BYTE;
        end else if (wr_en && apb_req_i.paddr == `OFS_COMPARE_VALUE_A) begin
            compare_value_a_r <= apb_req_i.pwdata[7:0];
        end
    end

    // compare value b
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            compare_value_b_r <= `RST_BYTE;
        end else if (wr_en && apb_req_i.paddr == `OFS_COMPARE_VALUE_B) begin
            compare_value_b_r <= apb_req_i.pwdata[7:0];
        end
    end

    // interrupt mask, one enable per flag
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            timer_mask_r <= `RST_FLAGS;
        end else if (wr_en && apb_req_i.paddr == `OFS_TIMER_MASK) begin
            timer_mask_r <= apb_req_i.pwdata[2:0];
        end
    end

    // free running prescaler
    // one shared prescaler feeds every divide tap, so the first tick
    // after a source change may come early
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            prescale_r <= 10'h000;
        end else begin
            prescale_r <= prescale_r + 10'h001;
        end
    end

    // external pin synchroniser and edge history
    // the pin is asynchronous: two flops before the edge detector
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_meta_r <= external_count_pin_i;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end

    // clock select: source and active edge
    // all eight codes are legal, so no default
    always_comb begin
        unique case (clock_source_select_r)
            CS_STOP: timer_tick = 1'b0;
            CS_DIV1: timer_tick = 1'b1;
            CS_DIV8: timer_tick = (prescale_r & `PRE_DIV8_M) == `PRE_DIV8_M;
            CS_DIV64: timer_tick = (prescale_r & `PRE_DIV64_M) == `PRE_DIV64_M;
            CS_DIV256: timer_tick = (prescale_r & `PRE_DIV256_M) == `PRE_DIV256_M;
            CS_DIV1024: timer_tick = (prescale_r & `PRE_DIV1024_M) == `PRE_DIV1024_M;
            CS_EXT_FALL: timer_tick = ext_prev_r && !ext_sync_r;
            CS_EXT_RISE: timer_tick = !ext_prev_r && ext_sync_r;
        endcase
    end

    // extreme and match indications
    assign at_bottom = counter_value_r == `CNT_BOTTOM;
    assign at_max = counter_value_r == `CNT_MAX;
    assign match_a = counter_value_r == compare_value_a_r;
    assign match_b = counter_value_r == compare_value_b_r;
    assign top_value = (waveform_mode_field == WGM_PC_CMPA ||
                        waveform_mode_field == WGM_FAST_CMPA) ?
                       compare_value_a_r : `CNT_MAX;
    assign at_top = counter_value_r == top_value;

    // next count and overflow event per mode
    always_comb begin
        counter_nxt = counter_value_r + 8'h01;
        count_down_nxt = count_down_r;
        overflow_evt = 1'b0;
        unique case (waveform_mode_field)
            WGM_CLEAR_ON_MATCH: begin
                if (match_a) begin
                    counter_nxt = `CNT_BOTTOM;
                end
                overflow_evt = at_max;
            end
            WGM_FAST_MAX, WGM_FAST_CMPA: begin
                if (at_top) begin
                    counter_nxt = `CNT_BOTTOM;
                end
                overflow_evt = at_top;
            end
            WGM_PC_MAX, WGM_PC_CMPA: begin
                if (count_down_r) begin
                    if (at_bottom) begin
                        count_down_nxt = 1'b0;
                        overflow_evt = 1'b1;
                    end else begin
                        counter_nxt = counter_value_r - 8'h01;
                    end
                end else if (at_top) begin
                    count_down_nxt = 1'b1;
                    counter_nxt = at_bottom ? `CNT_BOTTOM : counter_value_r - 8'h01;
                end
            end
            default: begin
                overflow_evt = at_max;
            end
        endcase
    end

    // counter: processor write wins over count and clear
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            counter_value_r <= `RST_BYTE;
        end else if (wr_counter) begin
            counter_value_r <= apb_req_i.pwdata[7:0];
        end else if (timer_tick) begin
            counter_value_r <= counter_nxt;
        end
    end

    // count direction, turned only by a tick that no write overrides
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            count_down_r <= 1'b0;
        end else if (timer_tick && !wr_counter) begin
            count_down_r <= count_down_nxt;
        end
    end

    // a counter write blocks the match of the following tick
    // so a compare preset equal to the count raises no flag at start
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            match_block_r <= 1'b0;
        end else if (wr_counter) begin
            match_block_r <= 1'b1;
        end else if (timer_tick) begin
            match_block_r <= 1'b0;
        end
    end

    // flag set terms, taken from the pre-tick count
    always_comb begin
        flag_set = `RST_FLAGS;
        if (timer_tick && !wr_counter) begin
            flag_set.ovf = overflow_evt;
            flag_set.cmp_a = match_a && !match_block_r;
            flag_set.cmp_b = match_b && !match_block_r;
        end
    end

    // flag clear terms from service and write-one-to-clear
    always_comb begin
        flag_clr = irq_ack_i;
        if (wr_en && (apb_req_i.paddr == `OFS_TIMER_FLAG ||
                      apb_req_i.paddr == `OFS_TIMER_FLAG_CLEAR)) begin
            flag_clr = flag_clr | apb_req_i.pwdata[2:0];
        end
    end

    // sticky flags, a set in the clearing cycle wins
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            timer_flag_r <= `RST_FLAGS;
        end else begin
            timer_flag_r <= (timer_flag_r & ~flag_clr) | flag_set;
        end
    end

    // masked interrupt request
    assign irq_o = |(timer_flag_r & timer_mask_r);

    // observed state
    assign counter_value_o = counter_value_r;
    assign bottom_o = at_bottom;
    assign max_o = at_max;

endmodule // timer8_core

`default_nettype wire

//--- sim/timer8_core_chk_sva.sv
// Purpose: port-level checker for the timer core
// Assumes: apb offsets from timer8_consts.svh
// Notes: control fields are mirrored from apb writes
`timescale 1ns/1ps
`include "timer8_consts.svh"
`default_nettype none
module timer8_core_chk (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // watched ports
    input wire timer8_pkg::apb_req_t apb_req_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire timer8_pkg::flags_t irq_ack_i,
    input wire logic irq_o,
    input wire logic [7:0] counter_value_o,
    input wire logic bottom_o,
    input wire logic max_o
);
    logic acc, wr, cnt_wr;
    logic [2:0] cs_r, mode_r, mask_r;
    logic [7:0] cmpa_r;
    assign acc = apb_req_i.psel && apb_req_i.penable && pready_o;
    assign wr = acc && apb_req_i.pwrite;
    assign cnt_wr = wr && apb_req_i.paddr == `OFS_COUNTER_VALUE;
    // mirror of control fields, compare a and mask
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cs_r <= 3'h0;
            mode_r <= 3'h0;
            mask_r <= 3'h0;
            cmpa_r <= 8'h00;
        end else if (wr) begin
            case (apb_req_i.paddr)
                `OFS_TIMER_CONTROL_A: mode_r[1:0] <= apb_req_i.pwdata[1:0];
                `OFS_TIMER_CONTROL_B: begin
                    cs_r <= apb_req_i.pwdata[2:0];
                    mode_r[2] <= apb_req_i.pwdata[3];
                end
                `OFS_TIMER_MASK: mask_r <= apb_req_i.pwdata[2:0];
                `OFS_COMPARE_VALUE_A: cmpa_r <= apb_req_i.pwdata[7:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // two quiet cycles, the second a tick at compare a
    sequence s_hit_a;
        !wr ##1 (!wr && cs_r == 3'h1 && mask_r[1] && counter_value_o == cmpa_r
            && !irq_ack_i.cmp_a);
    endsequence
    chk_reset_zero: assert property ($rose(resetn_i) |-> counter_value_o == 8'h00 && !irq_o)
        else $error("counter or irq not clear after reset");
    chk_ends_flags: assert property (bottom_o == (counter_value_o == 8'h00) && max_o == (counter_value_o == 8'hFF))
        else $error("bottom or max wrong");
    chk_stop_hold: assert property (cs_r == 3'h0 && !cnt_wr |=> $stable(counter_value_o))
        else $error("stopped counter moved");
    chk_up_step: assert property (cs_r == 3'h1 && mode_r == 3'h0 && !cnt_wr |=> counter_value_o == $past(counter_value_o) + 8'h01)
        else $error("normal mode step wrong");
    chk_write_wins: assert property (cnt_wr |=> counter_value_o == $past(apb_req_i.pwdata[7:0]))
        else $error("counter write lost");
    chk_ctc_clear: assert property (cs_r == 3'h1 && mode_r == 3'h2 && counter_value_o == cmpa_r && !cnt_wr |=> counter_value_o == 8'h00)
        else $error("no clear on compare a");
    chk_ovf_irq: assert property (cs_r == 3'h1 && mode_r == 3'h0 && mask_r[0] && counter_value_o == 8'hFF && !wr && !irq_ack_i.ovf |=> irq_o)
        else $error("overflow irq missing");
    chk_cmp_flag: assert property (s_hit_a |=> irq_o)
        else $error("compare a irq missing");
    chk_irq_mask: assert property (mask_r == 3'h0 |-> !irq_o)
        else $error("irq with all masked");
    chk_unmapped_err: assert property (acc |-> pslverr_o == !(apb_req_i.paddr[1:0] == 2'b00 && apb_req_i.paddr <= 8'h1C))
        else $error("slave error wrong");
endmodule // timer8_core_chk
bind timer8_core timer8_core_chk u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .apb_req_i(apb_req_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_ack_i(irq_ack_i),
    .irq_o(irq_o), .counter_value_o(counter_value_o), .bottom_o(bottom_o), .max_o(max_o));
`default_nettype wire

//--- sim/eight_bit_timer_counter_core_tb_top.sv
// Purpose: self-checking bench for the timer core
// Assumes: zero-wait apb slave, 50 MHz clock
// Notes: reads queue their expectation, a monitor compares
`timescale 1ns/1ps
`include "timer8_consts.svh"
`default_nettype none
module eight_bit_timer_counter_core_tb_top;
    import timer8_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, pin = 1'b0, irq, bot, mx, rdy, serr;
    apb_req_t req = '0;
    flags_t ack = '0;
    logic [31:0] rdata, rv;
    logic [7:0] cnt;
    logic [40:0] e;
    logic [40:0] exp_q[$];
    int err_count = 0, cmp_count = 0, cyc = 0, seed = 97407;
    always #10 clk = ~clk;
    timer8_core DUT (.core_clk_i(clk), .resetn_i(rstn), .apb_req_i(req), .prdata_o(rdata),
        .pready_o(rdy), .pslverr_o(serr), .external_count_pin_i(pin), .irq_ack_i(ack),
        .irq_o(irq), .counter_value_o(cnt), .bottom_o(bot), .max_o(mx));
    task stop_test;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk_rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] g);
        cmp_count++;
        if (g !== x) begin
            err_count++;
            $display("BAD reg %h exp %h got %h", a, x, g);
        end
    endtask
    task chk_irq(input logic x);
        @(negedge clk);
        cmp_count++;
        if (irq !== x) begin
            err_count++;
            $display("BAD irq exp %b got %b", x, irq);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        req <= '0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] x);
        exp_q.push_back({a, x});
        xfer(1'b0, a, 32'h0);
    endtask
    task wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
    endtask
    task pulses(input int n);
        repeat (n) begin
            @(posedge clk) pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    // read data monitor
    always @(posedge clk) begin
        if (req.psel && req.penable && !req.pwrite && rdy === 1'b1) begin
            e = exp_q.pop_front();
            chk_rd(e[40:33], e[32:0], {serr, rdata});
        end
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++) rd(8'(a * 4), 33'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, {1'b1, 32'h0});
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            rv = $random(seed);
            wr(`OFS_COUNTER_VALUE + 8'(4 * i), rv);
            repeat (20) @(posedge clk);
            rd(`OFS_COUNTER_VALUE + 8'(4 * i), {25'h0, rv[7:0]});
        end
        $display("test registers done");
        wr(`OFS_COMPARE_VALUE_A, 32'h0000_0080);
        wr(`OFS_COMPARE_VALUE_B, 32'h0000_0081);
        wr(`OFS_TIMER_MASK, 32'h0000_0001);
        wr(`OFS_COUNTER_VALUE, 32'h0000_00FD);
        wr(`OFS_TIMER_CONTROL_A, 32'h0000_0000);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0001);
        wait_irq(50);
        chk_irq(1'b1);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0000);
        rd(`OFS_TIMER_FLAG, 33'h1);
        wr(`OFS_TIMER_MASK, 32'h0000_0000);
        chk_irq(1'b0);
        wr(`OFS_TIMER_FLAG_CLEAR, 32'h0000_0001);
        rd(`OFS_TIMER_FLAG, 33'h0);
        $display("test overflow done");
        wr(`OFS_COUNTER_VALUE, 32'h0000_0000);
        wr(`OFS_COMPARE_VALUE_A, 32'h0000_0005);
        wr(`OFS_COMPARE_VALUE_B, 32'h0000_0003);
        wr(`OFS_TIMER_CONTROL_A, 32'h0000_0002);
        wr(`OFS_TIMER_MASK, 32'h0000_0002);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0001);
        wait_irq(50);
        chk_irq(1'b1);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0000);
        rd(`OFS_TIMER_FLAG, 33'h6);
        @(posedge clk) ack <= 3'b010;
        @(posedge clk) ack <= 3'b000;
        chk_irq(1'b0);
        rd(`OFS_TIMER_FLAG, 33'h4);
        $display("test clear on match done");
        wr(`OFS_TIMER_CONTROL_A, 32'h0000_0001);
        wr(`OFS_TIMER_MASK, 32'h0000_0001);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0001);
        wait_irq(700);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0000);
        rd(`OFS_TIMER_FLAG, 33'h7);
        wr(`OFS_TIMER_FLAG_CLEAR, 32'h0000_0007);
        $display("test up down done");
        wr(`OFS_TIMER_CONTROL_A, 32'h0000_0000);
        wr(`OFS_COUNTER_VALUE, 32'h0000_0000);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0007);
        pulses(4);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0006);
        pulses(3);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0000);
        rd(`OFS_COUNTER_VALUE, 33'h7);
        $display("test count pin done");
        wr(`OFS_TIMER_FLAG_CLEAR, 32'h0000_0007);
        wr(`OFS_COUNTER_VALUE, 32'h0000_0000);
        wr(`OFS_COMPARE_VALUE_A, 32'h0000_0003);
        wr(`OFS_TIMER_CONTROL_A, 32'h0000_0003);
        wr(`OFS_TIMER_MASK, 32'h0000_0001);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_000A);
        wait_irq(100);
        chk_irq(1'b1);
        wr(`OFS_TIMER_CONTROL_B, 32'h0000_0000);
        rd(`OFS_COUNTER_VALUE, 33'h0);
        rd(`OFS_TIMER_FLAG, 33'h7);
        $display("test fast prescaled done");
        stop_test();
    end
endmodule // eight_bit_timer_counter_core_tb_top
`default_nettype wire
